// file: logic/opc_core.sv
`timescale 1ns/1ps
// Overview of operation
// - control method bit: 0 selects PID, 1 selects on/off; resets to 0.
// - method and output mode bits only accept writes while stopped.
// - on/off: output turns off once pv reaches set point.
// - output turns back on only after pv falls by heating hysteresis.
// - direct/reverse setting sets on/off switching polarity in standard mode only.
// - heating output uses heating hysteresis, cooling uses cooling one.
// - standard mode always uses heating hysteresis, either direction.
// - cooling hysteresis ignored unless heating/cooling mode.
// - hysteresis clamps to 0.1..999.9, resets to 1.0, on/off only.
// - decimal point 0 is treated as one fractional digit.
// - inside dead band both heating and cooling mv are zero.
// - P, I, D held; defaults 8.0, 233 s, 40.0 s; I up to 3999.
// - tuning result load overwrites P, I, D constants.
// - proportional term linear in pv minus set point.
// - integral term accumulates error over time.
// - derivative term follows rate of change of pv.
// - x10 compensation multiplies effective band by 10 under PID.
// - compensation change takes effect only after software reset.
// - alpha held 0.00..1.00, default 0.65, PID only.
// - output mode bit: 0 standard, 1 heating/cooling; resets to 0.
// - direct (1) raises mv as pv rises; reverse (0) lowers it.
module opc_core #(
  parameter int PERIOD = opc_pkg::PERIOD_CYC  // control period in cycles
) (
  input wire logic clk_i,  // 50 MHz clock
  input wire logic rst_i,  // sync reset, high
  input wire logic soft_rst_i,  // software reset, high pulse
  input wire logic [7:0] wb_adr_i,  // byte address
  input wire logic [31:0] wb_dat_i,  // write data
  input wire logic [3:0] wb_sel_i,  // byte lanes
  input wire logic wb_we_i,  // write enable
  input wire logic wb_cyc_i,  // cycle
  input wire logic wb_stb_i,  // strobe
  output logic [31:0] wb_dat_o,  // read data
  output logic wb_ack_o,  // acknowledge
  output logic heat_out_o,  // heating control output
  output logic cool_out_o,  // cooling control output
  output logic [15:0] heat_mv_o,  // heating mv, tenths of %
  output logic [15:0] cool_mv_o  // cooling mv, tenths of %
);
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic run, method, mode, direct;
    logic signed [15:0] sp, pv, pv_prev, deadb;
    logic [15:0] hys_h, hys_c, pb, it, dt;
    logic [7:0] alpha;
    logic x10_req, x10_eff;
    logic [2:0] dp;
    logic [31:0] tick;
    logic signed [31:0] integ;
    logic heat, cool;
    logic [15:0] hmv, cmv;
    opc_pkg::opc_state_t st;
  } opc_regs_t;

  opc_regs_t q, d;

  // clamp a 16-bit parameter into its legal range
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // saturate a signed sum into 0..100.0 %
  function automatic logic [15:0] sat_mv(input logic signed [31:0] v);
    if (v < 0)
    begin
      sat_mv = 16'h0000;
    end
    else if (v > $signed({16'h0000, opc_pkg::MV_FULL}))
    begin
      sat_mv = opc_pkg::MV_FULL;
    end
    else
    begin
      sat_mv = v[15:0];
    end
  endfunction

  logic wr, rd_ok;
  logic signed [31:0] err, pterm, dterm, itrm, mv_raw, pband, hdb;
  logic signed [31:0] hys_h_s, hys_c_s;  // hysteresis widths, signed
  logic [15:0] hys_cool_eff;
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !q.ack;

  // next-state logic: bus slave, parameters, control law
  always_comb
  begin
    d = q;
    d.ack = wb_cyc_i && wb_stb_i && !q.ack;
    rd_ok = 1'b1;
    d.rdat = 32'h0000_0000;
    unique case (wb_adr_i)
      opc_pkg::OFF_CTRL: d.rdat = {28'h0, q.direct, q.mode, q.method, q.run};
      opc_pkg::OFF_SP: d.rdat = {{16{q.sp[15]}}, q.sp};
      opc_pkg::OFF_PV: d.rdat = {{16{q.pv[15]}}, q.pv};
      opc_pkg::OFF_HYS_H: d.rdat = {16'h0, q.hys_h};
      opc_pkg::OFF_HYS_C: d.rdat = {16'h0, q.hys_c};
      opc_pkg::OFF_DEADB: d.rdat = {{16{q.deadb[15]}}, q.deadb};
      opc_pkg::OFF_PBAND: d.rdat = {16'h0, q.pb};
      opc_pkg::OFF_ITIME: d.rdat = {16'h0, q.it};
      opc_pkg::OFF_DTIME: d.rdat = {16'h0, q.dt};
      opc_pkg::OFF_ALPHA: d.rdat = {24'h0, q.alpha};
      opc_pkg::OFF_COMMON: d.rdat = {25'h0, q.dp, 3'h0, q.x10_req};
      opc_pkg::OFF_STATUS: d.rdat = {28'h0, q.x10_eff, q.cool, q.heat,
                                     q.run};
      opc_pkg::OFF_MV: d.rdat = {q.cmv, q.hmv};
      default: rd_ok = 1'b0;  // unmapped reads as zero, still acked
    endcase
    if (!rd_ok)
    begin
      d.rdat = 32'h0000_0000;
    end
    // register writes, gated by the byte lane 0 select alone
    if (wr && wb_sel_i[0])
    begin
      unique case (wb_adr_i)
        opc_pkg::OFF_CTRL:
        begin
          d.run = wb_dat_i[opc_pkg::CTRL_RUN];
          d.direct = wb_dat_i[opc_pkg::CTRL_DIRECT];
          // selector changes refused while running
          if (!q.run)
          begin
            d.method = wb_dat_i[opc_pkg::CTRL_METHOD];
            d.mode = wb_dat_i[opc_pkg::CTRL_MODE];
          end
        end
        opc_pkg::OFF_SP: d.sp = wb_dat_i[15:0];
        opc_pkg::OFF_PV: d.pv = wb_dat_i[15:0];
        opc_pkg::OFF_HYS_H: d.hys_h = clamp16(wb_dat_i[15:0],
            opc_pkg::HYS_MIN, opc_pkg::HYS_MAX);
        opc_pkg::OFF_HYS_C: d.hys_c = clamp16(wb_dat_i[15:0],
            opc_pkg::HYS_MIN, opc_pkg::HYS_MAX);
        opc_pkg::OFF_DEADB: d.deadb = wb_dat_i[15:0];
        opc_pkg::OFF_PBAND: d.pb = clamp16(wb_dat_i[15:0],
            opc_pkg::HYS_MIN, opc_pkg::HYS_MAX);
        opc_pkg::OFF_ITIME: d.it = clamp16(wb_dat_i[15:0], 16'h0000,
            opc_pkg::IT_MAX);
        opc_pkg::OFF_DTIME: d.dt = clamp16(wb_dat_i[15:0], 16'h0000,
            opc_pkg::DT_MAX);
        opc_pkg::OFF_ALPHA: d.alpha = (wb_dat_i[7:0] > opc_pkg::ALPHA_MAX)
            ? opc_pkg::ALPHA_MAX : wb_dat_i[7:0];
        opc_pkg::OFF_COMMON:
        begin
          d.x10_req = wb_dat_i[opc_pkg::COM_X10];  // held until reset
          d.dp = wb_dat_i[opc_pkg::COM_DP +: 3];
        end
        opc_pkg::OFF_TUNE:
        begin
          // tuning engine result for the current set point
          d.pb = clamp16({8'h0, wb_dat_i[7:0]}, opc_pkg::HYS_MIN,
                         opc_pkg::HYS_MAX);
          d.it = {8'h0, wb_dat_i[15:8]};
          d.dt = {8'h0, wb_dat_i[23:16]};
        end
        default: ;
      endcase
    end
    // software reset latches the compensation request
    if (soft_rst_i)
    begin
      d.x10_eff = q.x10_req;
    end
    // error sign follows direct/reverse
    err = q.direct ? 32'(q.pv - q.sp) : 32'(q.sp - q.pv);
    // values in tenths regardless of dp=0
    pband = q.x10_eff ? 32'(q.pb) * 10 : 32'(q.pb);
    pterm = (err * 1000) / pband;
    dterm = 32'(q.pv - q.pv_prev) * $signed({16'h0000, q.dt})
            / pband;
    if (!q.direct)
    begin
      dterm = -dterm;
    end
    // integral share, zero time disables it
    itrm = (q.it == 16'h0) ? 32'sd0 : q.integ / $signed({16'h0000, q.it});
    mv_raw = pterm + itrm + dterm;
    hdb = 32'(q.deadb) >>> 1;
    // cooling hysteresis meaningful only in heating/cooling mode
    hys_cool_eff = q.mode ? q.hys_c : q.hys_h;
    // widened as signed, else a negative deviation compares as huge
    hys_h_s = $signed({16'h0000, q.hys_h});
    hys_c_s = $signed({16'h0000, hys_cool_eff});
    d.tick = (q.tick >= 32'(PERIOD - 1)) ? 32'h0 : q.tick + 32'h1;
    unique case (q.st)
      opc_pkg::OPC_IDLE:
      begin
        if (q.tick >= 32'(PERIOD - 1))
        begin
          d.st = opc_pkg::OPC_EVAL;
        end
      end
      opc_pkg::OPC_EVAL:
      begin
        d.st = opc_pkg::OPC_OUT;
        if (!q.run)
        begin
          d.heat = 1'b0;
          d.cool = 1'b0;
          d.hmv = 16'h0;
          d.cmv = 16'h0;
        end
        else if (q.method)
        begin
          // on/off with hysteresis
          if (!q.mode)
          begin
            if (err <= 0)
            begin
              d.heat = 1'b0;
            end
            else if (err >= hys_h_s)
            begin
              d.heat = 1'b1;
            end
            d.cool = 1'b0;
          end
          else
          begin
            // heat below sp, cool above, dead band between
            if (32'(q.pv - q.sp) >= -hdb)
            begin
              d.heat = 1'b0;
            end
            else if (32'(q.sp - q.pv) >= hdb + hys_h_s)
            begin
              d.heat = 1'b1;
            end
            if (32'(q.pv - q.sp) <= hdb)
            begin
              d.cool = 1'b0;
            end
            else if (32'(q.pv - q.sp) >= hdb + hys_c_s)
            begin
              d.cool = 1'b1;
            end
          end
          d.hmv = d.heat ? opc_pkg::MV_FULL : 16'h0;
          d.cmv = d.cool ? opc_pkg::MV_FULL : 16'h0;
        end
        else
        begin
          d.integ = q.integ + err;
          d.pv_prev = q.pv;
          if (q.mode && (32'(q.pv - q.sp) <= hdb)
              && (32'(q.sp - q.pv) <= hdb))
          begin
            d.hmv = 16'h0;
            d.cmv = 16'h0;
          end
          else if (q.mode)
          begin
            d.hmv = sat_mv(mv_raw);
            d.cmv = sat_mv(-mv_raw);
          end
          else
          begin
            d.hmv = sat_mv(mv_raw);
            d.cmv = 16'h0;
          end
          d.heat = (d.hmv != 16'h0);
          d.cool = (d.cmv != 16'h0);
        end
      end
      opc_pkg::OPC_OUT: d.st = opc_pkg::OPC_IDLE;
      default: d.st = opc_pkg::OPC_IDLE;
    endcase
  end

  // one register stage for the whole state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      q <= '0;
      q.hys_h <= opc_pkg::HYS_RST;
      q.hys_c <= opc_pkg::HYS_RST;
      q.pb <= opc_pkg::PB_RST;
      q.it <= opc_pkg::IT_RST;
      q.dt <= opc_pkg::DT_RST;
      q.alpha <= opc_pkg::ALPHA_RST;
      q.st <= opc_pkg::OPC_IDLE;
    end
    else
    begin
      q <= d;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.rdat;
  assign heat_out_o = q.heat;
  assign cool_out_o = q.cool;
  assign heat_mv_o = q.hmv;
  assign cool_mv_o = q.cmv;

  // checks: selector lock, on/off switching, dead band, timing, ranges
  property p_sel_lock;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(q.run) |-> q.method == $past(q.method);
  endproperty
  a_sel_lock: assert property (p_sel_lock)
    else $error("method changed while running");
  property p_mode_lock;
    @(posedge clk_i) disable iff (rst_i)
    !$past(rst_i) && $past(q.run) |-> q.mode == $past(q.mode);
  endproperty
  a_mode_lock: assert property (p_mode_lock)
    else $error("output mode changed while running");
  // in standard on/off mode, reaching the set point drops the heater
  property p_off_at_sp;
    @(posedge clk_i) disable iff (rst_i)
    q.st == opc_pkg::OPC_EVAL && q.run && q.method && !q.mode && err <= 0
    |=> !q.heat;
  endproperty
  a_off_at_sp: assert property (p_off_at_sp)
    else $error("heater left on at set point");
  // a heater that is off stays off until the full hysteresis drop
  property p_on_after_hys;
    @(posedge clk_i) disable iff (rst_i)
    q.st == opc_pkg::OPC_EVAL && q.run && q.method && !q.mode && !q.heat
    && err < hys_h_s |=> !q.heat;
  endproperty
  a_on_after_hys: assert property (p_on_after_hys)
    else $error("heater back on inside hysteresis");
  // outputs only move on the evaluation cycle
  property p_hold;
    @(posedge clk_i) disable iff (rst_i)
    q.st != opc_pkg::OPC_EVAL |=> $stable(q.hmv) && $stable(q.cmv);
  endproperty
  a_hold: assert property (p_hold)
    else $error("mv moved between evaluations");
  property p_hys_rng;
    @(posedge clk_i) disable iff (rst_i)
    q.hys_h >= opc_pkg::HYS_MIN && q.hys_h <= opc_pkg::HYS_MAX;
  endproperty
  a_hys_rng: assert property (p_hys_rng)
    else $error("heating hysteresis out of range");
  // pid in heating/cooling mode: both sides idle inside the band
  property p_db_zero;
    @(posedge clk_i) disable iff (rst_i)
    q.st == opc_pkg::OPC_EVAL && q.run && !q.method && q.mode
    && 32'(q.pv - q.sp) <= hdb && 32'(q.sp - q.pv) <= hdb
    |=> q.hmv == 16'h0000 && q.cmv == 16'h0000;
  endproperty
  a_db_zero: assert property (p_db_zero)
    else $error("mv not zero inside dead band");
  // the compensation only moves on a software reset
  property p_x10_hold;
    @(posedge clk_i) disable iff (rst_i)
    !soft_rst_i |=> $stable(q.x10_eff);
  endproperty
  a_x10_hold: assert property (p_x10_hold)
    else $error("compensation changed without software reset");
  // standard mode leaves the cooling side undriven once each evaluation is done
  property p_std_no_cool;
    @(posedge clk_i) disable iff (rst_i)
    q.st == opc_pkg::OPC_OUT && !q.mode |-> !q.cool && q.cmv == 16'h0000;
  endproperty
  a_std_no_cool: assert property (p_std_no_cool)
    else $error("cooling output active in standard mode");
  property p_ack;
    @(posedge clk_i) disable iff (rst_i)
    wb_cyc_i && wb_stb_i && !q.ack |=> q.ack ##1 !q.ack;
  endproperty
  a_ack: assert property (p_ack)
    else $error("ack timing");
  cover property (@(posedge clk_i) q.heat && q.method);
  cover property (@(posedge clk_i) q.cool && q.mode);
  cover property (@(posedge clk_i) q.cmv != 16'h0000 && !q.method);
  cover property (@(posedge clk_i) q.x10_eff);
endmodule

// file: logic/opc_pkg.sv
package opc_pkg;
  // register byte offsets on the wishbone slave
  localparam logic [7:0] OFF_CTRL = 8'h00;  // run, method, mode, direction
  localparam logic [7:0] OFF_SP = 8'h04;
  localparam logic [7:0] OFF_PV = 8'h08;
  localparam logic [7:0] OFF_HYS_H = 8'h0C;
  localparam logic [7:0] OFF_HYS_C = 8'h10;
  localparam logic [7:0] OFF_DEADB = 8'h14;
  localparam logic [7:0] OFF_PBAND = 8'h18;
  localparam logic [7:0] OFF_ITIME = 8'h1C;
  localparam logic [7:0] OFF_DTIME = 8'h20;
  localparam logic [7:0] OFF_ALPHA = 8'h24;
  localparam logic [7:0] OFF_COMMON = 8'h28;  // x10 compensation, dp
  localparam logic [7:0] OFF_TUNE = 8'h2C;  // tuning result load
  localparam logic [7:0] OFF_STATUS = 8'h30;
  localparam logic [7:0] OFF_MV = 8'h34;
  // ctrl and common bit positions
  localparam int CTRL_RUN = 0;
  localparam int CTRL_METHOD = 1;
  localparam int CTRL_MODE = 2;
  localparam int CTRL_DIRECT = 3;
  localparam int COM_X10 = 0;
  localparam int COM_DP = 4;  // 3-bit decimal-point field
  // reset values and limits, tenths of a unit unless noted
  localparam logic [15:0] HYS_RST = 16'h000A;  // 1.0
  localparam logic [15:0] HYS_MIN = 16'h0001;  // 0.1
  localparam logic [15:0] HYS_MAX = 16'h270F;  // 999.9
  localparam logic [15:0] PB_RST = 16'h0050;  // 8.0
  localparam logic [15:0] IT_RST = 16'h00E9;  // 233 s
  localparam logic [15:0] IT_MAX = 16'h0F9F;  // 3999 s
  localparam logic [15:0] DT_RST = 16'h0190;  // 40.0 s
  localparam logic [15:0] DT_MAX = 16'h270F;
  localparam logic [7:0] ALPHA_RST = 8'h41;  // 0.65 in hundredths
  localparam logic [7:0] ALPHA_MAX = 8'h64;  // 1.00
  localparam logic [15:0] MV_FULL = 16'h03E8;  // 100.0 %
  // control period
  localparam int CLK_HZ = 50_000_000;
  localparam int PERIOD_US = 100;
  localparam int PERIOD_CYC = CLK_HZ / 1_000_000 * PERIOD_US;
  typedef enum logic [1:0] {
    OPC_IDLE = 2'b00,
    OPC_EVAL = 2'b01,
    OPC_OUT = 2'b11
  } opc_state_t;
endpackage

// file: test/onoff_pid_control_select_test.sv
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end
module onoff_pid_control_select_test;
  localparam int PER = 20;
  logic clk_i = 1'b0, rst_i = 1'b1, soft_rst_i = 1'b0, plant_rst = 1'b1;
  logic [7:0] wb_adr_i = 8'h00;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rq;
  logic [3:0] wb_sel_i = 4'h0;
  logic wb_we_i = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_ack_o;
  logic heat_out_o, cool_out_o;
  logic [15:0] heat_mv_o, cool_mv_o, temp;
  int err_count = 0, checked = 0, cyc_cnt = 0;
  opc_core #(.PERIOD(PER)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .soft_rst_i(soft_rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .heat_out_o(heat_out_o), .cool_out_o(cool_out_o),
    .heat_mv_o(heat_mv_o), .cool_mv_o(cool_mv_o));
  opc_plant plant (.clk_i(clk_i), .rst_i(plant_rst), .heat_i(heat_out_o),
    .cool_i(cool_out_o), .temp_o(temp));
  always #10 clk_i = ~clk_i;
  // hang guard, well above the length of the whole sequence
  always @(posedge clk_i)
  begin
    cyc_cnt++;
    if (cyc_cnt == 30000)
    begin
      err_count++;
      summarize();
    end
  end
  task summarize();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // one classic cycle; request held until ack is sampled high
  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= 4'hF;
    // no cycle count assumed: only the hang guard ends this wait
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    rq = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask
  task rd(input logic [7:0] a);
    wb(1'b0, a, 32'h0);
  endtask
  // the law runs once per period; three periods cover any phase
  task settle();
    repeat (3 * PER + 4) @(posedge clk_i);
  endtask
  task pv(input logic [15:0] v);
    wr(opc_pkg::OFF_PV, {16'h0, v});
    settle();
  endtask
  initial
  begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(opc_pkg::OFF_CTRL); `CHK(rq, 32'h0)
    rd(opc_pkg::OFF_HYS_H); `CHK(rq[15:0], 16'h000A)
    rd(opc_pkg::OFF_HYS_C); `CHK(rq[15:0], 16'h000A)
    rd(opc_pkg::OFF_PBAND); `CHK(rq[15:0], 16'h0050)
    rd(opc_pkg::OFF_ITIME); `CHK(rq[15:0], 16'h00E9)
    rd(opc_pkg::OFF_DTIME); `CHK(rq[15:0], 16'h0190)
    rd(opc_pkg::OFF_ALPHA); `CHK(rq[7:0], 8'h41)
    // writes beyond range are clamped to the ends
    wr(opc_pkg::OFF_HYS_H, 32'h0);
    rd(opc_pkg::OFF_HYS_H); `CHK(rq[15:0], 16'h0001)
    wr(opc_pkg::OFF_HYS_H, 32'hFFFF);
    rd(opc_pkg::OFF_HYS_H); `CHK(rq[15:0], 16'h270F)
    wr(opc_pkg::OFF_ITIME, 32'hFFFF);
    rd(opc_pkg::OFF_ITIME); `CHK(rq[15:0], 16'h0F9F)
    wr(opc_pkg::OFF_ALPHA, 32'hFF);
    rd(opc_pkg::OFF_ALPHA); `CHK(rq[7:0], 8'h64)
    rd(8'hFC); `CHK(rq, 32'h0)
    wr(opc_pkg::OFF_HYS_H, 32'h000A);
    // on/off, standard, reverse: 100.0 set point
    wr(opc_pkg::OFF_CTRL, 32'h2);
    wr(opc_pkg::OFF_SP, 32'h03E8);
    wr(opc_pkg::OFF_CTRL, 32'h3);
    pv(16'h0384); `CHK({heat_out_o, cool_out_o}, 2'b10)
    wr(opc_pkg::OFF_CTRL, 32'h1);
    rd(opc_pkg::OFF_CTRL); `CHK(rq, 32'h3)
    pv(16'h03E8); `CHK(heat_out_o, 1'b0)
    pv(16'h03E3); `CHK(heat_out_o, 1'b0)
    pv(16'h03DE); `CHK(heat_out_o, 1'b1)
    // closed loop: load must stay near the set point
    plant_rst <= 1'b0;
    for (int i = 0; i < 150; i++)
    begin
      wr(opc_pkg::OFF_PV, {16'h0, temp});
      repeat (20) @(posedge clk_i);
      if (i > 40) `CHK(temp > 16'h03D9 && temp < 16'h03EE, 1'b1)
    end
    // direct operation flips the switching sense
    wr(opc_pkg::OFF_CTRL, 32'h2);
    wr(opc_pkg::OFF_CTRL, 32'hA);
    wr(opc_pkg::OFF_CTRL, 32'hB);
    pv(16'h03E8); `CHK(heat_out_o, 1'b0)
    pv(16'h03F2); `CHK(heat_out_o, 1'b1)
    // heating/cooling: cooling side keeps its own width
    wr(opc_pkg::OFF_CTRL, 32'h2);
    wr(opc_pkg::OFF_CTRL, 32'h6);
    wr(opc_pkg::OFF_HYS_C, 32'h1E);
    wr(opc_pkg::OFF_CTRL, 32'h7);
    pv(16'h03FC); `CHK({heat_out_o, cool_out_o}, 2'b00)
    pv(16'h0406); `CHK({heat_out_o, cool_out_o}, 2'b01)
    // PID, standard, reverse: below set point drives heat
    wr(opc_pkg::OFF_CTRL, 32'h0);
    wr(opc_pkg::OFF_CTRL, 32'h1);
    pv(16'h0384); `CHK(heat_mv_o > 16'h0, 1'b1)
    `CHK(heat_mv_o <= opc_pkg::MV_FULL, 1'b1)
    // dead band of 10.0 swallows a 2.0 deviation
    wr(opc_pkg::OFF_CTRL, 32'h0);
    wr(opc_pkg::OFF_DEADB, 32'h64);
    wr(opc_pkg::OFF_CTRL, 32'h5);
    pv(16'h03FC); `CHK({heat_mv_o, cool_mv_o}, 32'h0)
    // 10.0 above the set point: only the cooling side, saturated
    pv(16'h044C); `CHK({heat_mv_o, cool_mv_o}, 32'h0000_03E8)
    wr(opc_pkg::OFF_CTRL, 32'h0);
    settle(); `CHK({heat_out_o, heat_mv_o}, 17'h0)
    wr(opc_pkg::OFF_TUNE, 32'h563412);
    rd(opc_pkg::OFF_PBAND); `CHK(rq[15:0], 16'h0012)
    rd(opc_pkg::OFF_ITIME); `CHK(rq[15:0], 16'h0034)
    rd(opc_pkg::OFF_DTIME); `CHK(rq[15:0], 16'h0056)
    // x10 request waits for the software reset
    wr(opc_pkg::OFF_COMMON, 32'h1);
    rd(opc_pkg::OFF_COMMON); `CHK(rq, 32'h1)
    rd(opc_pkg::OFF_STATUS); `CHK(rq[3], 1'b0)
    @(posedge clk_i) soft_rst_i <= 1'b1;
    @(posedge clk_i) soft_rst_i <= 1'b0;
    rd(opc_pkg::OFF_STATUS); `CHK(rq[3], 1'b1)
    summarize();
  end
endmodule

// file: test/opc_plant.sv
`timescale 1ns/1ps
// thermal load seen by the heater and cooler outputs
module opc_plant #(
  parameter logic [15:0] START = 16'h03D4  // 98.0 at release
) (
  input wire logic clk_i,  // clock
  input wire logic rst_i,  // holds the load at START
  input wire logic heat_i,  // heater drive
  input wire logic cool_i,  // cooler drive
  output logic [15:0] temp_o  // temperature, tenths
);
  logic [3:0] div_q;
  // slow mass: one tenth per 16 cycles, so sampling keeps up with it
  always_ff @(posedge clk_i)
  begin
    div_q <= rst_i ? 4'h0 : div_q + 4'h1;
    if (rst_i)
      temp_o <= START;
    else if (div_q == 4'hF)
      temp_o <= (heat_i && !cool_i) ? temp_o + 16'h1 : temp_o - 16'h1;
  end
endmodule
